//--- rtl/aesg_cfg.svh
// Address map, field positions and reset values of the event-status group
`ifndef AESG_CFG_SVH
`define AESG_CFG_SVH
`define AESG_ADDR_W        13
`define AESG_OFF_ENMASK    13'h1058
`define AESG_OFF_RAW       13'h1060
`define AESG_OFF_MASKED    13'h1068
`define AESG_OFF_SWSET     13'h1070
`define AESG_OFF_CLR       13'h1078
`define AESG_OFF_IRQSTAT   13'h1080
`define AESG_OFF_IRQMASK   13'h1084
`define AESG_OFF_EXCLR     13'h1098
`define AESG_OFF_INDEX     13'h10a0
`define AESG_BIT_ABOVE     2
`define AESG_BIT_BELOW     3
`define AESG_BIT_INPUT     4
`define AESG_BIT_READY     8
`define AESG_LIVE_MASK     32'h0000011c
`define AESG_EVENT_MASK    32'h0000010c
`define AESG_WORD_RESET    32'h00000000
`define AESG_IDX_NONE      4'h0
`define AESG_IDX_READY     4'h9
`define AESG_IDX_BELOW     4'h4
`define AESG_IDX_ABOVE     4'h3
`define AESG_IDX_INPUT     4'h5
`define AESG_IRQ_W         3
`endif

//--- rtl/aesg_pkg.sv
// Types shared by the event-status group
package aesg_pkg;
   typedef logic [31:0] aesg_word_t;
   typedef enum logic [2:0] {
      AESG_RD_IDLE = 3'h1,
      AESG_RD_LIVE = 3'h2,
      AESG_RD_DONE = 3'h4
   } aesg_rdstate_t;
endpackage

//--- rtl/aesg_flag_bit.sv
// One sticky event flag: set wins over clear
`timescale 1ns/1ps
`include "aesg_cfg.svh"
module aesg_flag_bit (
   input  wire logic clock,
   input  wire logic rst_b,
   input  wire logic setEvent,
   input  wire logic clearEvent,
   output logic      flag
);
   logic flag_ff;
   logic nxt_flag;

   // Set wins so an event landing in the clearing cycle is kept
   always_comb begin
      nxt_flag = flag_ff;
      if (clearEvent) begin
         nxt_flag = 1'b0;
      end
      if (setEvent) begin
         nxt_flag = 1'b1;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         flag_ff <= 1'b0;
      end else begin
         flag_ff <= nxt_flag;
      end
   end

   assign flag = flag_ff;
endmodule

//--- rtl/aesg_event_status.sv
// Event-status group: raw flags, mask, masked view, software set and clear
// Behaviour
// - masked status equals mask AND raw
// - software set write raises raw flag
// - forced event shows masked when enabled
// - clear write 1 clears bit 8 only, 0 ignored
// - bit 8 set on new slot-zero result
// - slot-zero read or clear drops bit 8
// - bit 3 set below low window limit
// - bit 2 set above high window limit
// - index read or extended clear drops 2,3
// - bit 4 masks input event flag view
// - masked, set, clear registers reset zero
// - mask exposes flag in index and masked
// - clear works even with mask bit zero
`timescale 1ns/1ps
`include "aesg_cfg.svh"
module aesg_event_status (
   input  wire logic                     clock,
   input  wire logic                     rst_b,
   input  wire logic [`AESG_ADDR_W-1:0]  regAddr,
   input  wire logic [31:0]              regWrData,
   input  wire logic                     regWrite,
   input  wire logic                     regRead,
   output logic [31:0]                   regRdData,
   input  wire logic                     resultLoaded,
   input  wire logic                     resultSlotZeroRead,
   input  wire logic                     belowWindow,
   input  wire logic                     aboveWindow,
   input  wire logic                     inputEvent,
   output logic [31:0]                   maskedStatus,
   output logic [31:0]                   rawStatus,
   output logic [3:0]                    pendingIndex,
   output logic                          irq
);
   localparam int NumFlags = 4;
   localparam int FlagPos [NumFlags] = '{`AESG_BIT_ABOVE, `AESG_BIT_BELOW,
                                         `AESG_BIT_INPUT, `AESG_BIT_READY};

   aesg_pkg::aesg_word_t enableMask_ff;
   aesg_pkg::aesg_word_t rawWord;
   aesg_pkg::aesg_word_t maskedWord;
   aesg_pkg::aesg_word_t setWord;
   aesg_pkg::aesg_word_t clrWord;
   aesg_pkg::aesg_word_t hwSet;
   aesg_pkg::aesg_word_t hwClr;
   aesg_pkg::aesg_word_t rdData_ff;
   aesg_pkg::aesg_word_t nxt_rdData;
   logic [`AESG_IRQ_W-1:0] irqStat_ff;
   logic [`AESG_IRQ_W-1:0] irqMask_ff;
   logic [`AESG_IRQ_W-1:0] irqEvent;
   logic [3:0]             index;
   logic                   wrSet;
   logic                   wrClr;
   logic                   wrExClr;
   logic                   rdIndex;
   logic                   rdIrqStat;
   aesg_pkg::aesg_rdstate_t rdState_ff;
   aesg_pkg::aesg_rdstate_t nxt_rdState;
   logic [NumFlags-1:0]    flagOut;

   // Register strobes decoded once
   assign wrSet     = regWrite && (regAddr == `AESG_OFF_SWSET);
   assign wrClr     = regWrite && (regAddr == `AESG_OFF_CLR);
   assign wrExClr   = regWrite && (regAddr == `AESG_OFF_EXCLR);
   assign rdIndex   = regRead && (regAddr == `AESG_OFF_INDEX);
   assign rdIrqStat = regRead && (regAddr == `AESG_OFF_IRQSTAT);

   // Set and clear registers are write-only pulses; they read back as zero
   // Every live bit, the input event included, can be forced for diagnostics
   assign setWord = wrSet ? (regWrData & `AESG_LIVE_MASK)
                          : `AESG_WORD_RESET;
   assign clrWord = wrClr ? (regWrData & `AESG_EVENT_MASK) : `AESG_WORD_RESET;

   // Hardware event sources mapped onto their bit positions
   always_comb begin
      hwSet = `AESG_WORD_RESET;
      hwClr = `AESG_WORD_RESET;
      hwSet[`AESG_BIT_READY] = resultLoaded;
      hwSet[`AESG_BIT_BELOW] = belowWindow;
      hwSet[`AESG_BIT_ABOVE] = aboveWindow;
      hwSet[`AESG_BIT_INPUT] = inputEvent;
      // Slot-zero read and clear-register write both drop the ready flag
      hwClr[`AESG_BIT_READY] = resultSlotZeroRead || clrWord[`AESG_BIT_READY];
      // Window flags clear on index read or extended clear, not on the plain clear
      hwClr[`AESG_BIT_BELOW] = rdIndex || (wrExClr && regWrData[`AESG_BIT_BELOW]);
      hwClr[`AESG_BIT_ABOVE] = rdIndex || (wrExClr && regWrData[`AESG_BIT_ABOVE]);
      hwClr[`AESG_BIT_INPUT] = wrExClr && regWrData[`AESG_BIT_INPUT];
   end

   // One sticky flag per live bit; clears ignore the mask entirely
   always_comb begin
      rawWord = `AESG_WORD_RESET;
      for (int i = 0; i < NumFlags; i++) begin
         rawWord[FlagPos[i]] = flagOut[i];
      end
   end

   generate
      for (genvar g = 0; g < NumFlags; g++) begin : gFlag
         aesg_flag_bit uFlag (
            .clock      (clock),
            .rst_b      (rst_b),
            .setEvent   (hwSet[FlagPos[g]] || setWord[FlagPos[g]]),
            .clearEvent (hwClr[FlagPos[g]] || (g != NumFlags - 1 && g < 2 ?
                                               1'b0 : clrWord[FlagPos[g]])),
            .flag       (flagOut[g])
         );
      end
   endgenerate

   // Enable mask, reserved bits forced to zero
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         enableMask_ff <= `AESG_WORD_RESET;
      end else if (regWrite && (regAddr == `AESG_OFF_ENMASK)) begin
         enableMask_ff <= regWrData & `AESG_LIVE_MASK;
      end
   end

   // Masked view is combinational so a forced event shows the same cycle as raw
   assign maskedWord = enableMask_ff & rawWord;

   // Pending index: highest-priority unmasked flag, zero when none
   always_comb begin
      index = `AESG_IDX_NONE;
      if (maskedWord[`AESG_BIT_INPUT]) begin
         index = `AESG_IDX_INPUT;
      end
      if (maskedWord[`AESG_BIT_ABOVE]) begin
         index = `AESG_IDX_ABOVE;
      end
      if (maskedWord[`AESG_BIT_BELOW]) begin
         index = `AESG_IDX_BELOW;
      end
      if (maskedWord[`AESG_BIT_READY]) begin
         index = `AESG_IDX_READY;
      end
   end

   // Interrupt status: ready, below, above events; a read of it clears it
   assign irqEvent = {hwSet[`AESG_BIT_READY] | setWord[`AESG_BIT_READY],
                      hwSet[`AESG_BIT_BELOW] | setWord[`AESG_BIT_BELOW],
                      hwSet[`AESG_BIT_ABOVE] | setWord[`AESG_BIT_ABOVE]};

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         irqStat_ff <= '0;
      end else begin
         // New events win over the read clear
         irqStat_ff <= (rdIrqStat ? '0 : irqStat_ff) | irqEvent;
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         irqMask_ff <= '0;
      end else if (regWrite && (regAddr == `AESG_OFF_IRQMASK)) begin
         irqMask_ff <= regWrData[`AESG_IRQ_W-1:0];
      end
   end

   // Read-data tracker, mostly for visibility of read timing
   always_comb begin
      case (rdState_ff)
         aesg_pkg::AESG_RD_IDLE: nxt_rdState = regRead ? aesg_pkg::AESG_RD_LIVE
                                                        : aesg_pkg::AESG_RD_IDLE;
         aesg_pkg::AESG_RD_LIVE: nxt_rdState = regRead ? aesg_pkg::AESG_RD_LIVE
                                                        : aesg_pkg::AESG_RD_DONE;
         aesg_pkg::AESG_RD_DONE: nxt_rdState = regRead ? aesg_pkg::AESG_RD_LIVE
                                                        : aesg_pkg::AESG_RD_IDLE;
         default:                nxt_rdState = aesg_pkg::AESG_RD_IDLE;
      endcase
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdState_ff <= aesg_pkg::AESG_RD_IDLE;
      end else begin
         rdState_ff <= nxt_rdState;
      end
   end

   // Read mux; unmapped addresses and write-only registers return zero
   always_comb begin
      nxt_rdData = `AESG_WORD_RESET;
      if (regRead) begin
         case (regAddr)
            `AESG_OFF_ENMASK:  nxt_rdData = enableMask_ff;
            `AESG_OFF_RAW:     nxt_rdData = rawWord;
            `AESG_OFF_MASKED:  nxt_rdData = maskedWord;
            `AESG_OFF_INDEX:   nxt_rdData = {28'h0000000, index};
            `AESG_OFF_IRQSTAT: nxt_rdData = {29'h00000000, irqStat_ff};
            `AESG_OFF_IRQMASK: nxt_rdData = {29'h00000000, irqMask_ff};
            default:           nxt_rdData = `AESG_WORD_RESET;
         endcase
      end
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rdData_ff <= `AESG_WORD_RESET;
      end else begin
         rdData_ff <= nxt_rdData;
      end
   end

   assign regRdData    = rdData_ff;
   assign maskedStatus = maskedWord;
   assign rawStatus    = rawWord;
   assign pendingIndex = index;
   // Level interrupt while any unmasked interrupt-status bit (ready, below, above) is set
   assign irq          = |(irqStat_ff & irqMask_ff);
endmodule

//--- test/aesg_event_status_properties.sv
// Port-level checker for the event-status group
`timescale 1ns/1ps
`include "aesg_cfg.svh"
module aesg_event_status_properties (
   input wire logic                    clock,
   input wire logic                    rst_b,
   input wire logic [`AESG_ADDR_W-1:0] regAddr,
   input wire logic [31:0]             regWrData,
   input wire logic                    regWrite,
   input wire logic                    regRead,
   input wire logic [31:0]             regRdData,
   input wire logic                    resultLoaded,
   input wire logic                    resultSlotZeroRead,
   input wire logic                    belowWindow,
   input wire logic                    aboveWindow,
   input wire logic                    inputEvent,
   input wire logic [31:0]             maskedStatus,
   input wire logic [31:0]             rawStatus,
   input wire logic [3:0]              pendingIndex,
   input wire logic                    irq
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);
   // Bus strobes aimed at one register
   sequence s_wr(a);
      regWrite && regAddr == a;
   endsequence
   sequence s_rd(a);
      regRead && regAddr == a;
   endsequence
   a_masked_subset: assert property ((maskedStatus & ~rawStatus) == 32'h0)
      else $error("masked bit set without raw bit");
   a_reserved_zero: assert property (((rawStatus | maskedStatus) & ~`AESG_LIVE_MASK) == 32'h0)
      else $error("reserved status bit set");
   a_ready_set: assert property (resultLoaded |=> rawStatus[8])
      else $error("ready flag not set");
   a_window_set: assert property ((belowWindow || aboveWindow) |=>
      (rawStatus[3:2] & $past({belowWindow, aboveWindow})) == $past({belowWindow, aboveWindow}))
      else $error("window flag not set");
   a_swset_raw: assert property (s_wr(`AESG_OFF_SWSET) |=>
      (rawStatus & $past(regWrData) & `AESG_LIVE_MASK) == ($past(regWrData) & `AESG_LIVE_MASK))
      else $error("software set missed a flag");
   a_clear_ready: assert property (s_wr(`AESG_OFF_CLR) ##0
      regWrData[8] && !resultLoaded |=> !rawStatus[8])
      else $error("clear did not drop ready flag");
   a_clear_zero: assert property (s_wr(`AESG_OFF_CLR) ##0
      !regWrData[8] && rawStatus[8] && !resultSlotZeroRead |=> rawStatus[8])
      else $error("clear of zero dropped ready flag");
   a_slot_read: assert property (resultSlotZeroRead && !resultLoaded && !regWrite
      |=> !rawStatus[8])
      else $error("slot read kept ready flag");
   a_index_clear: assert property (s_rd(`AESG_OFF_INDEX) ##0
      !belowWindow && !aboveWindow |=> rawStatus[3:2] == 2'h0)
      else $error("index read kept window flags");
   a_read_masked: assert property (s_rd(`AESG_OFF_MASKED) |=> regRdData == $past(maskedStatus))
      else $error("masked read data wrong");
   a_read_wo: assert property (regRead &&
      (regAddr == `AESG_OFF_SWSET || regAddr == `AESG_OFF_CLR) |=> regRdData == 32'h0)
      else $error("write-only register read nonzero");
endmodule
bind aesg_event_status aesg_event_status_properties u_props (.clock(clock), .rst_b(rst_b),
   .regAddr(regAddr), .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead),
   .regRdData(regRdData), .resultLoaded(resultLoaded), .resultSlotZeroRead(resultSlotZeroRead),
   .belowWindow(belowWindow), .aboveWindow(aboveWindow), .inputEvent(inputEvent),
   .maskedStatus(maskedStatus), .rawStatus(rawStatus), .pendingIndex(pendingIndex), .irq(irq));

//--- test/tb_adc_event_status_group.sv
// Self-checking bench for the event-status group
`timescale 1ns/1ps
`include "aesg_cfg.svh"
module tb_adc_event_status_group;
   logic                    clock = 1'b0;
   logic                    rst_b = 1'b0;
   logic [`AESG_ADDR_W-1:0] regAddr = 13'h0;
   logic [31:0]             regWrData = 32'h0;
   logic                    regWrite = 1'b0;
   logic                    regRead = 1'b0;
   logic [4:0]              evPulse = 5'h0;
   logic [31:0]             regRdData, maskedStatus, rawStatus;
   logic [3:0]              pendingIndex;
   logic                    irq;
   int                      err_count = 0;
   int                      checked = 0;
   aesg_event_status u_dut (.clock(clock), .rst_b(rst_b), .regAddr(regAddr),
      .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .resultLoaded(evPulse[4]), .resultSlotZeroRead(evPulse[3]), .belowWindow(evPulse[2]),
      .aboveWindow(evPulse[1]), .inputEvent(evPulse[0]), .maskedStatus(maskedStatus),
      .rawStatus(rawStatus), .pendingIndex(pendingIndex), .irq(irq));
   // 200 MHz clock
   always #2.5 clock = ~clock;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Bus cycles end just after the taking edge so results are settled
   task automatic wr(input logic [12:0] a, input logic [31:0] d);
      @(posedge clock);
      regAddr   <= a;
      regWrData <= d;
      regWrite  <= 1'b1;
      @(posedge clock);
      regWrite  <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [12:0] a, input logic [31:0] e);
      @(posedge clock);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1 chk(regRdData, e);
   endtask
   task automatic pulse(input logic [4:0] v);
      @(posedge clock);
      evPulse <= v;
      @(posedge clock);
      evPulse <= 5'h0;
      #1;
   endtask
   task automatic t_reset;
      chk(rawStatus, 32'h0);
      rd(`AESG_OFF_MASKED, 32'h0);
      rd(`AESG_OFF_SWSET, 32'h0);
      rd(`AESG_OFF_CLR, 32'h0);
      rd(13'h0000, 32'h0);
   endtask
   // Hardware events with the interrupt masked, then unmasked and cleared
   task automatic t_events;
      wr(`AESG_OFF_IRQMASK, 32'h0);
      pulse(5'h10);
      chk(rawStatus, 32'h100);
      pulse(5'h04);
      chk(rawStatus, 32'h108);
      pulse(5'h02);
      chk(rawStatus, 32'h10c);
      pulse(5'h01);
      chk(rawStatus, 32'h11c);
      chk(maskedStatus, 32'h0);
      chk({31'h0, irq}, 32'h0);
      wr(`AESG_OFF_IRQMASK, 32'h7);
      chk({31'h0, irq}, 32'h1);
      rd(`AESG_OFF_IRQSTAT, 32'h7);
      chk({31'h0, irq}, 32'h0);
   endtask
   // Each enable bit exposes its flag in both views
   task automatic t_mask;
      logic [31:0] m [4] = '{32'h100, 32'h008, 32'h004, 32'h010};
      logic [3:0]  x [4] = '{4'h9, 4'h4, 4'h3, 4'h5};
      for (int i = 0; i < 4; i++) begin
         wr(`AESG_OFF_ENMASK, m[i]);
         chk(maskedStatus, m[i]);
         chk({28'h0, pendingIndex}, {28'h0, x[i]});
      end
      wr(`AESG_OFF_ENMASK, 32'hffffffff);
      rd(`AESG_OFF_MASKED, 32'h11c);
   endtask
   task automatic t_clear;
      wr(`AESG_OFF_ENMASK, 32'h0);
      wr(`AESG_OFF_CLR, 32'h0);
      chk(rawStatus, 32'h11c);
      wr(`AESG_OFF_CLR, 32'hffffffff);
      chk(rawStatus, 32'h01c);
      pulse(5'h10);
      pulse(5'h08);
      chk(rawStatus, 32'h01c);
      rd(`AESG_OFF_INDEX, 32'h0);
      chk(rawStatus, 32'h010);
      wr(`AESG_OFF_EXCLR, 32'h10);
      chk(rawStatus, 32'h0);
   endtask
   task automatic t_swset;
      wr(`AESG_OFF_ENMASK, 32'h100);
      wr(`AESG_OFF_SWSET, 32'hffffffff);
      chk(rawStatus, 32'h11c);
      rd(`AESG_OFF_MASKED, 32'h100);
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // Hang guard: a bounded run that counts as a mismatch
   initial begin
      repeat (20000) @(posedge clock);
      err_count++;
      final_report;
   end
   initial begin
      repeat (20) @(posedge clock);
      rst_b <= 1'b1;
      t_reset;
      t_events;
      t_mask;
      t_clear;
      t_swset;
      final_report;
   end
endmodule
